// ---- ldc_pkg.sv ----
package ldc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Bus geometry
    localparam int unsigned ADR_W  = 10;
    localparam int unsigned DAT_W  = 32;
    localparam int unsigned IDX_W  = 8;
    localparam int unsigned MEM_AW = 6;
    localparam int unsigned MEM_DEPTH = 64;

    ////////////////////////////////////////////////////////////////////////
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CLR   = 8'h60;
    localparam logic [7:0] IDX_LOCK  = 8'h61;
    localparam logic [7:0] IDX_MISC6 = 8'h62;
    localparam logic [7:0] IDX_MISC7 = 8'h63;
    localparam logic [7:0] IDX_MISC8 = 8'h64;
    localparam logic [7:0] IDX_THR   = 8'h5B;
    // Per-channel banks: current, duty high part, duty low part
    localparam logic [1:0] BANK_CUR  = 2'h0;
    localparam logic [1:0] BANK_DHI  = 2'h1;
    localparam logic [1:0] BANK_DLO  = 2'h2;
    localparam logic [3:0] CHAN_CNT  = 4'hC;

    ////////////////////////////////////////////////////////////////////////
    // Clear and force command bits
    localparam int unsigned CLR_FORCE_FS  = 5;
    localparam int unsigned CLR_RESTORE   = 4;
    localparam int unsigned CLR_FORCE_ERR = 3;
    localparam int unsigned CLR_EXIT_FS   = 2;
    localparam int unsigned CLR_FAULTS    = 1;
    localparam int unsigned CLEAR_POWERUP_FLAG_CMD       = 0;

    // Lock bits
    localparam int unsigned LOCK_CLR  = 3;
    localparam int unsigned LOCK_CONF = 2;
    localparam int unsigned LOCK_CUR  = 1;
    localparam int unsigned LOCK_DUTY = 0;

    // Sixth and seventh miscellaneous register fields
    localparam int unsigned M6_STAY   = 7;
    localparam int unsigned M6_RELOAD = 6;
    localparam int unsigned M6_CH_HI  = 4;
    localparam int unsigned M7_EXTCLK = 5;
    localparam int unsigned M7_SHARE  = 4;
    localparam int unsigned M7_RDSH   = 1;
    localparam int unsigned M7_PROG   = 0;

    ////////////////////////////////////////////////////////////////////////
    // Values after reset
    localparam logic [7:0] CLR_RST   = 8'h00;
    localparam logic [3:0] LOCK_RST  = 4'hF;
    localparam logic [7:0] MISC6_RST = 8'h00;
    localparam logic [7:0] MISC7_RST = 8'h00;
    localparam logic [7:0] MISC8_RST = 8'h00;
    localparam logic [7:0] CHAN_RST  = 8'h00;

    // Operating state
    typedef enum logic {
        FS_NORMAL = 1'b0,
        FS_SAFE   = 1'b1
    } ldc_fs_t;

endpackage : ldc_pkg

// ---- ldc_chan_mem.sv ----
`timescale 1ns/1ps
module ldc_chan_mem (
    // Clock and reset
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    // Access port
    input  wire logic                      clr_i,
    input  wire logic                      we_i,
    input  wire logic [ldc_pkg::MEM_AW-1:0] addr_i,
    input  wire logic [7:0]                wdata_i,
    output logic      [7:0]                rdata_o
);
    import ldc_pkg::*;

    typedef struct packed {
        logic [MEM_DEPTH-1:0][7:0] mem;
        logic [7:0]                rdata;
    } ldc_mem_t;

    ldc_mem_t st;
    ldc_mem_t next_st;

    ////////////////////////////////////////////////////////////////////////
    // Read is registered so data lines up with the bus answer
    always_comb begin
        next_st       = st;
        next_st.rdata = st.mem[addr_i];
        if (we_i) begin
            next_st.mem[addr_i] = wdata_i;
        end
        // Clear beats a write landing in the same cycle
        if (clr_i) begin
            next_st.mem = {MEM_DEPTH{CHAN_RST}};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '{mem: {MEM_DEPTH{CHAN_RST}}, rdata: 8'h00};
        end else begin
            st <= next_st;
        end
    end

    assign rdata_o = st.rdata;

endmodule : ldc_chan_mem

// ---- ldc_regs.sv ----
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
module ldc_regs (
    // Clock and reset
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    // Wishbone slave
    input  wire logic                      cyc_i,
    input  wire logic                      stb_i,
    input  wire logic                      we_i,
    input  wire logic [ldc_pkg::ADR_W-1:0] adr_i,
    input  wire logic [3:0]                sel_i,
    input  wire logic [ldc_pkg::DAT_W-1:0] dat_i,
    output logic      [ldc_pkg::DAT_W-1:0] dat_o,
    output logic                           ack_o,
    // Nonvolatile copy
    input  wire logic [7:0]                short_threshold_nv_copy_i,
    // Command pulses
    output logic                           restore_defaults_o,
    output logic                           clear_faults_o,
    output logic                           clear_powerup_flag_o,
    output logic                           nv_reload_o,
    output logic                           adc_start_o,
    // Settings and state
    output logic                           failsafe_o,
    output logic      [4:0]                converter_channel_select_o,
    output logic                           stay_nv_state_o,
    output logic                           pwm_ext_clock_select_o,
    output logic                           shared_duty_enable_o,
    output logic                           readback_source_select_o,
    output logic                           nv_program_state_enable_o,
    output logic      [7:0]                short_threshold_field_o,
    output logic      [7:0]                fault_mask_diag_o,
    // Open-drain error pin
    output logic                           err_o,
    output logic                           err_oe_o
);
    import ldc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic       ack;
        logic       from_mem;
        logic [7:0] rdata;
        ldc_fs_t    fs;
        logic [3:0] lock;
        logic       stay;
        logic [4:0] adc_ch;
        logic       ext_clk;
        logic       share;
        logic       rd_shadow;
        logic       prog;
        logic [7:0] misc8;
        logic [7:0] thr;
        logic       err_forced;
        logic       restore;
        logic       clear_faults_cmd;
        logic       clear_powerup_flag_cmd;
        logic       reload;
        logic       adc_start;
    } ldc_state_t;

    ldc_state_t      st;
    ldc_state_t      next_st;
    logic [IDX_W-1:0] idx;
    logic            req;
    logic            wr_ok;
    logic            clr_wr;
    logic            mem_we;
    logic [7:0]      mem_q;

    ////////////////////////////////////////////////////////////////////////
    // Functions

    // Channel banks: three banks of twelve, at index 00h, 10h, 20h
    function automatic logic mem_hit(input logic [7:0] a);
        mem_hit = (a[7:6] == 2'h0) && (a[5:4] != 2'h3)
                  && (a[3:0] < CHAN_CNT);
    endfunction : mem_hit

    // Unmapped and locked targets both return zero
    function automatic logic write_open(input logic [7:0] a,
                                        input logic [3:0] lk);
        write_open = 1'b0;
        if (mem_hit(a)) begin
            if (a[5:4] == BANK_CUR) begin
                write_open = ~lk[LOCK_CUR];
            end else begin
                write_open = ~lk[LOCK_DUTY];
            end
        end else begin
            case (a)
                IDX_CLR:   write_open = ~lk[LOCK_CLR];
                IDX_LOCK:  write_open = 1'b1;
                IDX_MISC6,
                IDX_MISC7,
                IDX_MISC8,
                IDX_THR:   write_open = ~lk[LOCK_CONF];
                default:   write_open = 1'b0;
            endcase
        end
    endfunction : write_open

    // Settings back to defaults; threshold comes from the nv copy
    function automatic ldc_state_t apply_defaults(input ldc_state_t s,
                                                  input logic [7:0] nv);
        apply_defaults           = s;
        apply_defaults.lock      = LOCK_RST;
        apply_defaults.stay      = MISC6_RST[M6_STAY];
        apply_defaults.adc_ch    = MISC6_RST[M6_CH_HI:0];
        apply_defaults.ext_clk   = MISC7_RST[M7_EXTCLK];
        apply_defaults.share     = MISC7_RST[M7_SHARE];
        apply_defaults.rd_shadow = MISC7_RST[M7_RDSH];
        apply_defaults.prog      = MISC7_RST[M7_PROG];
        apply_defaults.misc8     = MISC8_RST;
        apply_defaults.thr       = nv;
    endfunction : apply_defaults

    // Command bits are never stored, so they always read zero
    function automatic logic [7:0] read_local(input logic [7:0] a,
                                              input ldc_state_t s);
        case (a)
            IDX_CLR:   read_local = CLR_RST;
            IDX_LOCK:  read_local = {4'h0, s.lock};
            IDX_MISC6: read_local = {s.stay, 2'h0, s.adc_ch};
            IDX_MISC7: read_local = {2'h0, s.ext_clk, s.share, 2'h0,
                                     s.rd_shadow, s.prog};
            IDX_MISC8: read_local = s.misc8;
            IDX_THR:   read_local = s.thr;
            default:   read_local = 8'h00;
        endcase
    endfunction : read_local

    ////////////////////////////////////////////////////////////////////////
    // Bus decode; writes land on the edge where ack is sampled
    assign idx    = adr_i[ADR_W-1:2];
    assign req    = cyc_i & stb_i;
    assign wr_ok  = req & we_i & st.ack & sel_i[0]
                    & write_open(idx, st.lock);
    assign clr_wr = wr_ok & (idx == IDX_CLR);
    assign mem_we = wr_ok & mem_hit(idx);

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        next_st           = st;
        next_st.ack       = req & ~st.ack;
        // Pulses last exactly one cycle
        next_st.restore   = 1'b0;
        next_st.clear_faults_cmd = 1'b0;
        next_st.clear_powerup_flag_cmd   = 1'b0;
        next_st.reload    = 1'b0;
        next_st.adc_start = 1'b0;
        // Read data sampled in the cycle the request arrives
        if (req & ~st.ack) begin
            next_st.rdata    = read_local(idx, st);
            next_st.from_mem = mem_hit(idx);
        end
        // Forced error holds until faults are cleared; set wins
        next_st.err_forced = (st.err_forced
                              & ~(clr_wr & dat_i[CLR_FAULTS]))
                             | (clr_wr & dat_i[CLR_FORCE_ERR]);
        if (wr_ok) begin
            case (idx)
                IDX_CLR: begin
                    if (dat_i[CLR_RESTORE]) begin
                        next_st = apply_defaults(next_st,
                                      short_threshold_nv_copy_i);
                        next_st.restore = 1'b1;
                    end
                    if (dat_i[CLR_FORCE_FS] && st.fs == FS_NORMAL) begin
                        next_st.fs = FS_SAFE;
                    end else if (dat_i[CLR_EXIT_FS]
                                 && st.fs == FS_SAFE) begin
                        next_st.fs = FS_NORMAL;
                    end
                    next_st.clear_faults_cmd = dat_i[CLR_FAULTS];
                    next_st.clear_powerup_flag_cmd   = dat_i[CLEAR_POWERUP_FLAG_CMD];
                end
                IDX_LOCK: begin
                    next_st.lock = dat_i[3:0];
                end
                IDX_MISC6: begin
                    next_st.stay      = dat_i[M6_STAY];
                    next_st.adc_ch    = dat_i[M6_CH_HI:0];
                    next_st.adc_start = 1'b1;
                    next_st.reload    = dat_i[M6_RELOAD];
                    if (dat_i[M6_RELOAD]) begin
                        next_st.thr = short_threshold_nv_copy_i;
                    end
                end
                IDX_MISC7: begin
                    next_st.ext_clk   = dat_i[M7_EXTCLK];
                    next_st.share     = dat_i[M7_SHARE];
                    next_st.rd_shadow = dat_i[M7_RDSH];
                    next_st.prog      = dat_i[M7_PROG];
                end
                IDX_MISC8: begin
                    next_st.misc8 = dat_i[7:0];
                end
                IDX_THR: begin
                    next_st.thr = dat_i[7:0];
                end
                default: begin
                    next_st.lock = st.lock;
                end
            endcase
        end
    end

    // Threshold picks up the nv copy while reset is held
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= apply_defaults('0, short_threshold_nv_copy_i);
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Channel registers; cleared one cycle after a restore command
    ldc_chan_mem u_chan_mem (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .clr_i   (st.restore),
        .we_i    (mem_we),
        .addr_i  (idx[MEM_AW-1:0]),
        .wdata_i (dat_i[7:0]),
        .rdata_o (mem_q)
    );

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign ack_o  = st.ack;
    assign dat_o  = {24'h000000, (st.from_mem ? mem_q : st.rdata)};
    assign restore_defaults_o         = st.restore;
    assign clear_faults_o             = st.clear_faults_cmd;
    assign clear_powerup_flag_o       = st.clear_powerup_flag_cmd;
    assign nv_reload_o                = st.reload;
    assign adc_start_o                = st.adc_start;
    assign failsafe_o                 = (st.fs == FS_SAFE);
    assign converter_channel_select_o = st.adc_ch;
    assign stay_nv_state_o            = st.stay;
    assign pwm_ext_clock_select_o     = st.ext_clk;
    assign shared_duty_enable_o       = st.share;
    assign readback_source_select_o   = st.rd_shadow;
    assign nv_program_state_enable_o  = st.prog;
    assign short_threshold_field_o    = st.thr;
    assign fault_mask_diag_o          = st.misc8;
    // Pin only ever pulled low, never driven high
    assign err_o    = 1'b0;
    assign err_oe_o = st.err_forced;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_wr(logic [7:0] a, int b);
        req && we_i && ack_o && sel_i[0] && idx == a && dat_i[b];
    endsequence

    sequence s_open(int b);
        !st.lock[b];
    endsequence

    sequence s_pulse(logic p);
        p ##1 !p;
    endsequence

    force_fs_a: assert property (
        s_wr(IDX_CLR, CLR_FORCE_FS) and s_open(LOCK_CLR)
        and !failsafe_o |=> failsafe_o)
        else $error("fail-safe not entered");

    restore_a: assert property (
        s_wr(IDX_CLR, CLR_RESTORE) and s_open(LOCK_CLR)
        |=> s_pulse(restore_defaults_o) and st.lock == LOCK_RST)
        else $error("restore defaults missing");

    err_force_a: assert property (
        s_wr(IDX_CLR, CLR_FORCE_ERR) and s_open(LOCK_CLR)
        |=> err_oe_o && !err_o)
        else $error("error pin not forced");

    exit_fs_a: assert property (
        s_wr(IDX_CLR, CLR_EXIT_FS) and s_open(LOCK_CLR)
        and failsafe_o |=> !failsafe_o)
        else $error("fail-safe not left");

    fault_clr_a: assert property (
        s_wr(IDX_CLR, CLR_FAULTS) and s_open(LOCK_CLR)
        |=> s_pulse(clear_faults_o))
        else $error("fault clear pulse wrong");

    por_clr_a: assert property (
        s_wr(IDX_CLR, CLEAR_POWERUP_FLAG_CMD) and s_open(LOCK_CLR)
        |=> s_pulse(clear_powerup_flag_o))
        else $error("power-up clear pulse wrong");

    clr_reads_zero_a: assert property (
        ack_o && !we_i && $past(idx) == IDX_CLR
        && $past(req) |-> dat_o == 32'h00000000)
        else $error("clear register read nonzero");

    clr_locked_a: assert property (
        req && we_i && ack_o && idx == IDX_CLR
        && st.lock[LOCK_CLR] |=> !clear_faults_o
        && !clear_powerup_flag_o && !restore_defaults_o
        && $stable(failsafe_o))
        else $error("locked clear register acted");

    conf_locked_a: assert property (
        req && we_i && ack_o && idx == IDX_MISC7
        && st.lock[LOCK_CONF] |=> $stable(pwm_ext_clock_select_o)
        && $stable(nv_program_state_enable_o))
        else $error("locked configuration changed");

    lock_reset_a: assert property (
        $fell(rst_i) |-> st.lock == LOCK_RST
        ##1 (!req || st.lock == LOCK_RST))
        else $error("lock not set after reset");

    reload_a: assert property (
        s_wr(IDX_MISC6, M6_RELOAD) and s_open(LOCK_CONF)
        |=> s_pulse(nv_reload_o)
        and short_threshold_field_o == $past(short_threshold_nv_copy_i))
        else $error("nv reload missing");

    adc_start_a: assert property (
        req && we_i && ack_o && sel_i[0] && idx == IDX_MISC6
        && !st.lock[LOCK_CONF] |=> adc_start_o
        && converter_channel_select_o == $past(dat_i[M6_CH_HI:0]))
        else $error("conversion not started");

    ack_once_a: assert property (
        ack_o |=> !ack_o ##1 !restore_defaults_o)
        else $error("ack held too long");

endmodule : ldc_regs

// ---- ldc_host_model.sv ----
`timescale 1ns/1ps
module ldc_host_model (
    // Clock
    input  wire logic        clk_i,
    // Wishbone master side
    output logic             cyc_o,
    output logic             stb_o,
    output logic             we_o,
    output logic [9:0]       adr_o,
    output logic [3:0]       sel_o,
    output logic [31:0]      dat_o,
    input  wire logic [31:0] dat_i,
    input  wire logic        ack_i
);
    ////////////////////////////////////////////////////////////////////////
    // Bus idle from time zero
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o  = 1'b0;
        adr_o = 10'h000;
        sel_o = 4'h0;
        dat_o = 32'h0000_0000;
    end

    ////////////////////////////////////////////////////////////////////////
    // One classic cycle; request held until ack is sampled high
    task automatic xfer(input logic w, input logic [7:0] idx,
                        input logic [7:0] wd, output logic [7:0] rd,
                        output logic ok);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o  <= w;
        adr_o <= {idx, 2'h0};
        sel_o <= 4'h1;
        dat_o <= {24'h00_0000, wd};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_i !== 1'b1 && n < 40);
        ok = (ack_i === 1'b1);
        rd = dat_i[7:0];
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        // Stale data must not look like a held value
        dat_o <= ~dat_o;
    endtask : xfer
endmodule : ldc_host_model

// ---- tb_ldc_regs.sv ----
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin \
    errors++; $display("[ERR] %s exp %0h got %0h", nm, ex, got); end end
module tb_ldc_regs;
    import ldc_pkg::*;
    logic        clk_i, rst_i, cyc, stb, we, ack, rdef, cflt, cpor, nvrl;
    logic        adcs, fs, stay, ext, shr, rdsh, prog, err, err_oe;
    logic [9:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat;
    logic [7:0]  nv, thr, fmd, d;
    logic [4:0]  chs;
    int          errors, num_checks, seed, i;

    ////////////////////////////////////////////////////////////////////////
    ldc_regs ldc_regs_inst (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
        .dat_o(rdat), .ack_o(ack), .short_threshold_nv_copy_i(nv),
        .restore_defaults_o(rdef), .clear_faults_o(cflt),
        .clear_powerup_flag_o(cpor), .nv_reload_o(nvrl),
        .adc_start_o(adcs), .failsafe_o(fs),
        .converter_channel_select_o(chs), .stay_nv_state_o(stay),
        .pwm_ext_clock_select_o(ext), .shared_duty_enable_o(shr),
        .readback_source_select_o(rdsh),
        .nv_program_state_enable_o(prog),
        .short_threshold_field_o(thr), .fault_mask_diag_o(fmd),
        .err_o(err), .err_oe_o(err_oe));
    ldc_host_model ldc_host_model_inst (
        .clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
        .sel_o(sel), .dat_o(wdat), .dat_i(rdat), .ack_i(ack));

    // Free-running bench clock, 50 ns period
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    ////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic results();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : results

    // Register access; a missing ack ends the run
    task automatic acc(input logic w, input logic [7:0] idx,
                       input logic [7:0] wd, output logic [7:0] r);
        logic ok;
        ldc_host_model_inst.xfer(w, idx, wd, r, ok);
        if (ok !== 1'b1) begin
            errors++;
            results();
        end
    endtask : acc
    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        logic [7:0] r;
        acc(1'b1, idx, wd, r);
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] idx, input logic [7:0] ex);
        logic [7:0] r;
        acc(1'b0, idx, 8'h00, r);
        `CHK("rdata", ex, r)
    endtask : rd

    // Readable bits of each register; the rest read zero
    function automatic logic [7:0] rd_mask(input logic [7:0] idx);
        case (idx)
            IDX_CLR:   rd_mask = 8'h00;
            IDX_LOCK:  rd_mask = 8'h0F;
            IDX_MISC6: rd_mask = 8'h9F;
            IDX_MISC7: rd_mask = 8'h33;
            default:   rd_mask = 8'hFF;
        endcase
    endfunction : rd_mask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        errors = 0;
        num_checks = 0;
        seed = 4245;
        rst_i = 1'b1;
        nv = $random(seed);
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(IDX_LOCK, 8'h0F);
        rd(IDX_CLR, 8'h00);
        rd(IDX_THR, nv);
        `CHK("fs", 1'b0, fs)
        // Everything but the lock register locked after reset: writes are dropped
        wr(IDX_CLR, 8'h20);
        `CHK("fs", 1'b0, fs)
        wr(IDX_MISC7, 8'h33);
        rd(IDX_MISC7, 8'h00);
        wr(8'h00, 8'h5A);
        rd(8'h00, 8'h00);
        wr(8'h10, 8'hA5);
        rd(8'h10, 8'h00);
        wr(IDX_LOCK, 8'hF0);
        rd(IDX_LOCK, 8'h00);
        // Command bits, each acting once
        wr(IDX_CLR, 8'h20);
        `CHK("fs", 1'b1, fs)
        rd(IDX_CLR, 8'h00);
        wr(IDX_CLR, 8'h04);
        `CHK("fs", 1'b0, fs)
        wr(IDX_CLR, 8'h08);
        `CHK("err_oe", 1'b1, err_oe)
        wr(IDX_CLR, 8'h02);
        `CHK("clr_flt", 1'b1, cflt)
        `CHK("err_oe", 1'b0, err_oe)
        @(posedge clk_i);
        #1;
        `CHK("clr_flt", 1'b0, cflt)
        wr(IDX_CLR, 8'h01);
        `CHK("clear_powerup_flag_cmd", 1'b1, cpor)
        // Force and clear-faults in one write: the force wins
        wr(IDX_CLR, 8'h0A);
        `CHK("err_oe", 1'b1, err_oe)
        `CHK("err", 1'b0, err)
        // Random settings through the misc and threshold registers and channels 0 to 7 of the current and duty low banks
        for (i = 0; i < 8; i++) begin
            d = $random(seed);
            wr(IDX_MISC6, d & 8'hBF);
            `CHK("adc_go", 1'b1, adcs)
            `CHK("adc_ch", d[4:0], chs)
            `CHK("stay", d[7], stay)
            rd(IDX_MISC6, d & rd_mask(IDX_MISC6));
            wr(IDX_MISC7, d);
            `CHK("ext", d[5], ext)
            `CHK("share", d[4], shr)
            `CHK("rdsh", d[1], rdsh)
            `CHK("prog", d[0], prog)
            rd(IDX_MISC7, d & rd_mask(IDX_MISC7));
            wr(IDX_THR, d);
            rd(IDX_THR, d);
            wr(IDX_MISC8, ~d);
            `CHK("fmd", ~d, fmd)
            wr(i[7:0], d);
            rd(i[7:0], d);
            wr(8'h20 + i[7:0], ~d);
            rd(8'h20 + i[7:0], ~d);
        end
        // Reload from the nonvolatile copy
        nv <= $random(seed);
        wr(IDX_MISC6, 8'h40);
        `CHK("nv_rl", 1'b1, nvrl)
        `CHK("thr", nv, thr)
        rd(IDX_MISC6, 8'h00);
        // Restore defaults brings the locks back
        wr(IDX_CLR, 8'h10);
        `CHK("rdef", 1'b1, rdef)
        rd(IDX_LOCK, 8'h0F);
        rd(IDX_MISC7, 8'h00);
        rd(IDX_THR, nv);
        rd(8'h00, 8'h00);
        // Unmapped place: acked, ignored, reads zero
        wr(8'hF0, 8'hFF);
        rd(8'hF0, 8'h00);
        results();
    end
endmodule : tb_ldc_regs
